/* dv/ckds_osc_model.sv */
// partner model: watchdog oscillator that times the reset delay
`timescale 1ns/10ps
module ckds_osc_model (
  // speed select
  input wire logic i_slow,
  // oscillator pin
  output logic o_wdt_osc
);
  ////////////////////////////////////////////////////////////////
  initial begin
    o_wdt_osc = 1'b0;
    forever begin
      #((i_slow === 1'b1) ? 53.3 : 17.7);
      o_wdt_osc = ~o_wdt_osc;
    end
  end
endmodule : ckds_osc_model

/* dv/tb.sv */
// self-checking bench for the clock divider and source select top
`timescale 1ns/10ps
module tb;
  import ckds_pkg::*;
  ////////////////////////////////////////////////////////////////
  logic i_clk, i_rst_n, i_wr, i_rd, i_wake, i_async_irq_pin, i_twi_addr_match;
  logic i_wdt_osc, slow;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata, d;
  logic o_core_en, o_periph_en, o_conv_en, o_prog_en, o_async_timer_en, o_async_wake;
  logic [2:0] o_source;
  int n_fail, total_checks, cyc, wdt_rises, en_m, sel_m, k, nc, nv;

  ckds_top #(.RESET_SHORT(8), .RESET_LONG(16)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_wdt_osc(i_wdt_osc),
    .i_wake(i_wake), .i_async_irq_pin(i_async_irq_pin),
    .i_twi_addr_match(i_twi_addr_match), .o_core_en(o_core_en),
    .o_periph_en(o_periph_en), .o_conv_en(o_conv_en), .o_prog_en(o_prog_en),
    .o_async_timer_en(o_async_timer_en), .o_async_wake(o_async_wake),
    .o_source(o_source)
  );
  ckds_osc_model i_osc (.i_slow(slow), .o_wdt_osc(i_wdt_osc));

  ////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_wdt_osc) wdt_rises++;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    if (a == CKDS_OFS_DIV && v[7] && en_m == 0) sel_m = v[6:0];
    if (a == CKDS_OFS_DIV) en_m = v[7];
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    chk_val(o_rdata, exp);
    @(posedge i_clk);
    chk_val(o_rdata, 8'h00);
  endtask : reg_rd

  task automatic wait_core(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_core_en !== 1'b1 && n < 2000);
  endtask : wait_core

  task automatic measure_chk;
    int p;
    repeat (3) wait_core(p);
    chk_val({o_periph_en, o_conv_en, o_prog_en}, 3'b111);
    chk_val(p, en_m ? 129 - sel_m : 1);
  endtask : measure_chk

  ////////////////////////////////////////////////////////////////
  initial begin
    {i_rst_n, i_wr, i_rd, i_wake, i_async_irq_pin, i_twi_addr_match, slow} = '0;
    i_addr = '0;
    i_wdata = '0;
    void'($urandom(32'hcfd6d896));
    for (int r = 0; r < 2; r++) begin
      slow <= r[0];
      i_rst_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      chk_val({o_core_en, o_rdata}, 9'h0);
      i_rst_n <= 1'b1;
      wdt_rises = 0;
      en_m = 0;
      sel_m = 0;
      wait_core(k);
      chk_val(wdt_rises >= 8 && wdt_rises <= 9, 1);
    end
    chk_val(o_source, CKDS_SRC_INTRC);
    chk_val(o_async_timer_en, 1'b1);
    reg_rd(CKDS_OFS_DIV, DIV_RESET);
    reg_rd(CKDS_OFS_STATUS, {4'h2, FUSE_SRC_DEFAULT});
    reg_rd(4'hf, 8'h00);
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'h7f : (i == 1) ? 8'h00 : 8'($urandom_range(0, 127));
      reg_wr(CKDS_OFS_DIV, 8'h80 | d);
      reg_wr(CKDS_OFS_DIV, 8'h80 | 8'($urandom_range(0, 127)));
      reg_rd(CKDS_OFS_DIV, 8'(128 + sel_m));
      measure_chk();
      reg_wr(CKDS_OFS_DIV, 8'($urandom_range(0, 127)));
      reg_rd(CKDS_OFS_DIV, 8'(sel_m));
      measure_chk();
    end
    reg_wr(CKDS_OFS_GATE, 8'h03);
    reg_rd(CKDS_OFS_GATE, 8'h03);
    nc = 0;
    nv = 0;
    repeat (4) @(posedge i_clk);
    repeat (200) begin
      @(posedge i_clk);
      nc += (o_core_en !== 1'b0) + (o_periph_en !== 1'b0);
      nv += (o_conv_en === 1'b1);
    end
    chk_val(nc, 0);
    chk_val(nv, 200);
    for (int j = 0; j < 2; j++) begin
      {i_async_irq_pin, i_twi_addr_match} <= j ? 2'b01 : 2'b10;
      k = 0;
      do begin
        @(posedge i_clk);
        k++;
      end while (o_async_wake !== 1'b1 && k < 8);
      chk_val(k < 8, 1);
      {i_async_irq_pin, i_twi_addr_match} <= 2'b00;
      repeat (8) @(posedge i_clk);
      chk_val(o_async_wake, 1'b0);
    end
    reg_wr(CKDS_OFS_GATE, 8'h00);
    i_wake <= 1'b1;
    @(posedge i_clk);
    i_wake <= 1'b0;
    repeat (2) @(posedge i_clk);
    wait_core(k);
    chk_val(k + 2 >= 1022 && k + 2 <= 1030, 1);
    end_sim();
  end
endmodule : tb

/* src/ckds_divider.sv */
// glitch-free clock enable divider
`timescale 1ns/10ps
module ckds_divider
  import ckds_pkg::*;
#(
  parameter int FACT_W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_run,
  input wire logic i_div_en,
  input wire logic [FACT_W-1:0] i_factor,
  // enable out
  output logic o_tick
);

  initial begin
    if (FACT_W < 8) $error("divider width too small");
  end

  logic [FACT_W-1:0] cnt_reg;
  logic [FACT_W-1:0] fact_reg;
  logic en_reg;

  // settings are taken only at a period boundary so no short period occurs
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      fact_reg <= FACT_W'(2);
      en_reg <= 1'b0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      o_tick <= 1'b0;
    end else if (!en_reg || cnt_reg == fact_reg - FACT_W'(1)) begin
      cnt_reg <= '0;
      fact_reg <= i_factor;
      en_reg <= i_div_en;
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + FACT_W'(1);
      o_tick <= 1'b0;
    end
  end

endmodule : ckds_divider

/* src/ckds_pkg.sv */
// package: constants for the clock divider and source select block
package ckds_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int SEL_W = 7;
  localparam int FUSE_W = 4;
  localparam int SUT_W = 2;

  // register offsets
  localparam logic [ADDR_W-1:0] CKDS_OFS_DIV = 4'h0;
  localparam logic [ADDR_W-1:0] CKDS_OFS_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] CKDS_OFS_GATE = 4'h2;

  // divide control fields
  localparam int DIV_EN_BIT = 7;
  localparam int DIV_SEL_LSB = 0;
  localparam logic [DATA_W-1:0] DIV_RESET = 8'h00;
  localparam logic [7:0] DIV_BASE = 8'h81;

  // gate register fields
  localparam int GATE_CORE_BIT = 0;
  localparam int GATE_PERIPH_BIT = 1;
  localparam int GATE_CONV_BIT = 2;
  localparam int GATE_PROG_BIT = 3;
  localparam logic [DATA_W-1:0] GATE_RESET = 8'h00;

  // fuse defaults
  localparam logic [FUSE_W-1:0] FUSE_SRC_DEFAULT = 4'h1;
  localparam logic [SUT_W-1:0] FUSE_SUT_DEFAULT = 2'h2;

  // fuse decode limits
  localparam logic [FUSE_W-1:0] FUSE_XTAL_LO = 4'ha;
  localparam logic [FUSE_W-1:0] FUSE_LFXTAL = 4'h9;
  localparam logic [FUSE_W-1:0] FUSE_EXTRC_LO = 4'h5;
  localparam logic [FUSE_W-1:0] FUSE_INTRC_LO = 4'h1;

  typedef enum logic [2:0] {
    CKDS_SRC_EXTCLK = 3'b000,
    CKDS_SRC_INTRC = 3'b001,
    CKDS_SRC_EXTRC = 3'b010,
    CKDS_SRC_LFXTAL = 3'b011,
    CKDS_SRC_XTAL = 3'b100
  } ckds_src_e;

  // start-up counts
  localparam int WAKE_CYC_SHORT = 1024;
  localparam int WAKE_CYC_LONG = 16384;
  localparam int RESET_CYC_SHORT = 4096;
  localparam int RESET_CYC_LONG = 65536;
  localparam int CNT_W = 17;

endpackage : ckds_pkg

/* src/ckds_startup.sv */
// start-up delay counter
`timescale 1ns/10ps
module ckds_startup
  import ckds_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_start,
  input wire logic i_tick,
  input wire logic [CNT_W-1:0] i_count,
  // status
  output logic o_busy,
  output logic o_done
);

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        cnt_reg <= i_count;
        o_busy <= 1'b1;
      end else if (o_busy && i_tick) begin
        if (cnt_reg <= CNT_W'(1)) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_reg - CNT_W'(1);
        end
      end
    end
  end

endmodule : ckds_startup

/* src/ckds_top.sv */
// clock divider, source select and domain gating top
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module ckds_top
  import ckds_pkg::*;
#(
  parameter logic [FUSE_W-1:0] SRC_FUSES = FUSE_SRC_DEFAULT,
  parameter logic [SUT_W-1:0] SUT_FUSES = FUSE_SUT_DEFAULT,
  parameter int RESET_SHORT = RESET_CYC_SHORT,
  parameter int RESET_LONG = RESET_CYC_LONG
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // pins and sleep control
  input wire logic i_wdt_osc,
  input wire logic i_wake,
  input wire logic i_async_irq_pin,
  input wire logic i_twi_addr_match,
  // domain enables
  output logic o_core_en,
  output logic o_periph_en,
  output logic o_conv_en,
  output logic o_prog_en,
  output logic o_async_timer_en,
  output logic o_async_wake,
  output logic [2:0] o_source
);

  initial begin
    if (RESET_SHORT < 1 || RESET_LONG >= (1 << CNT_W)) $error("bad reset delay count");
  end

  //////////////////////////////////////////////////////////////////////////////
  // fuse decode

  ckds_src_e src_sel;
  always_comb begin
    if (SRC_FUSES >= FUSE_XTAL_LO) src_sel = CKDS_SRC_XTAL;
    else if (SRC_FUSES == FUSE_LFXTAL) src_sel = CKDS_SRC_LFXTAL;
    else if (SRC_FUSES >= FUSE_EXTRC_LO) src_sel = CKDS_SRC_EXTRC;
    else if (SRC_FUSES >= FUSE_INTRC_LO) src_sel = CKDS_SRC_INTRC;
    else src_sel = CKDS_SRC_EXTCLK;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] meta_reg;
  logic [2:0] sync_reg;
  logic wdt_prev_reg;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_reg <= 3'h1;
      sync_reg <= 3'h1;
      wdt_prev_reg <= 1'b1;
    end else begin
      meta_reg <= {i_twi_addr_match, i_async_irq_pin, i_wdt_osc};
      sync_reg <= meta_reg;
      wdt_prev_reg <= sync_reg[0];
    end
  end
  logic wdt_tick;
  assign wdt_tick = sync_reg[0] && !wdt_prev_reg;

  //////////////////////////////////////////////////////////////////////////////
  // divide control and gate registers

  logic div_en_reg;
  logic [SEL_W-1:0] div_sel_reg;
  logic [DATA_W-1:0] gate_reg;
  logic wr_div;
  assign wr_div = i_wr && i_addr == CKDS_OFS_DIV;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      div_en_reg <= DIV_RESET[DIV_EN_BIT];
      div_sel_reg <= DIV_RESET[SEL_W-1:0];
    end else if (wr_div) begin
      div_en_reg <= i_wdata[DIV_EN_BIT];
      if (!div_en_reg && i_wdata[DIV_EN_BIT]) begin
        div_sel_reg <= i_wdata[DIV_SEL_LSB +: SEL_W];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) gate_reg <= GATE_RESET;
    else if (i_wr && i_addr == CKDS_OFS_GATE) gate_reg <= i_wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // start-up sequencing

  logic rst_seen_reg;
  logic run_reg;
  logic start_pulse;
  logic [CNT_W-1:0] start_count;
  logic su_busy;
  logic su_done;
  logic reset_phase_reg;
  logic sys_tick;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rst_seen_reg <= 1'b0;
      reset_phase_reg <= 1'b1;
      run_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
      if (su_done) begin
        run_reg <= 1'b1;
        reset_phase_reg <= 1'b0;
      end else if (i_wake && run_reg) begin
        run_reg <= 1'b0;
      end
    end
  end

  assign start_pulse = !rst_seen_reg || (i_wake && run_reg);

  always_comb begin
    if (!rst_seen_reg) begin
      start_count = SUT_FUSES[0] ? CNT_W'(RESET_LONG) : CNT_W'(RESET_SHORT);
    end else if (src_sel == CKDS_SRC_XTAL || src_sel == CKDS_SRC_LFXTAL) begin
      start_count = CNT_W'(WAKE_CYC_LONG);
    end else begin
      start_count = CNT_W'(WAKE_CYC_SHORT);
    end
  end

  ckds_startup u_startup (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(start_pulse),
    .i_tick(reset_phase_reg ? wdt_tick : 1'b1),
    .i_count(start_count),
    .o_busy(su_busy),
    .o_done(su_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // divider

  ckds_divider #(.FACT_W(8)) u_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_run(run_reg),
    .i_div_en(div_en_reg),
    .i_factor(DIV_BASE - {1'b0, div_sel_reg}),
    .o_tick(sys_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // domain enables

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_core_en <= 1'b0;
      o_periph_en <= 1'b0;
      o_conv_en <= 1'b0;
      o_prog_en <= 1'b0;
      o_async_timer_en <= 1'b0;
      o_async_wake <= 1'b0;
      o_source <= 3'h0;
    end else begin
      o_core_en <= sys_tick && !gate_reg[GATE_CORE_BIT];
      o_prog_en <= sys_tick && !gate_reg[GATE_CORE_BIT] && !gate_reg[GATE_PROG_BIT];
      o_periph_en <= sys_tick && !gate_reg[GATE_PERIPH_BIT];
      o_conv_en <= sys_tick && !gate_reg[GATE_CONV_BIT];
      o_async_timer_en <= 1'b1;
      o_async_wake <= sync_reg[1] || sync_reg[2];
      o_source <= src_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_rd) begin
      case (i_addr)
        CKDS_OFS_DIV: o_rdata <= {div_en_reg, div_sel_reg};
        CKDS_OFS_STATUS: o_rdata <= {2'h0, run_reg, su_busy, SRC_FUSES};
        CKDS_OFS_GATE: o_rdata <= gate_reg;
        default: o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_SEL_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    div_en_reg && !$past(!div_en_reg) |-> $stable(div_sel_reg))
    else $error("select changed while enabled");
  AST_SEL_ADOPT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_div && !div_en_reg && i_wdata[DIV_EN_BIT] |=> div_sel_reg == $past(i_wdata[6:0]))
    else $error("select not adopted");
  AST_EN_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    wr_div && !i_wdata[DIV_EN_BIT] |=> !div_en_reg && $stable(div_sel_reg))
    else $error("clear write mishandled");
  AST_UNDIV: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    run_reg && !div_en_reg && !u_div.en_reg |=> sys_tick)
    else $error("undivided clock missing");
  AST_NO_SHORT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sys_tick && div_en_reg && u_div.en_reg |=> !sys_tick)
    else $error("short divided period");
  AST_ASYNC_RUN: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_seen_reg |=> o_async_timer_en)
    else $error("async timer stopped");
  AST_PROG_CORE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_prog_en |-> o_core_en)
    else $error("program store without core");
  AST_NO_RUN_BUSY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    su_busy |-> ##2 !o_core_en)
    else $error("core ran during start-up");

endmodule : ckds_top
